// ---- rpm_ctrl.sv ----
// Rear module power, hot-swap and pin isolation controller
// How it works
// - Serial management clock and data are high impedance while no rear module is present.
// - Test mode, test clock and test data outputs are high impedance while no module is present.
// - Zone-3 drive enable is high only in state M4 and low in every other state.
// - Presence is an active-low pulled-up input, low meaning module inserted.
// - Payload power is switched with inrush limiting and a programmable overcurrent threshold.
// - Current limiting active for 300 ms continuously shuts payload power down, leaves management power on and flags a fault.
// - Startup uses a raised 50 W limit, then switches to the configured LIMIT_CFG_W limit.
`timescale 1ns/1ps
`default_nettype none
module rpm_ctrl
   import rpm_pkg::*;
#(
   parameter int FAULT_CNT = FAULT_CYCLES,
   parameter int STARTUP_CNT = STARTUP_CYCLES
) (
   // System
   input wire logic CLK_SYS,
   input wire logic RST,
   // Module sense and power switch
   input wire logic REAR_MODULE_PRESENT_N,
   input wire logic CURRENT_LIMITING,
   input wire logic [7:0] LIMIT_CFG_W,
   input wire logic FAULT_CLEAR,
   output logic REAR_MGMT_POWER_OUT,
   output logic REAR_PAYLOAD_POWER_OUT,
   output logic [7:0] CURRENT_LIMIT_W,
   output logic FAULT,
   // Carrier FPGA
   output logic ZONE3_DRIVE_ENABLE,
   // Management serial
   input wire logic REAR_MGMT_SERIAL_CLOCK_I,
   input wire logic REAR_MGMT_SERIAL_CLOCK_O,
   output logic REAR_MGMT_SERIAL_CLOCK_OUT,
   output logic REAR_MGMT_SERIAL_CLOCK_OE,
   input wire logic REAR_MGMT_SERIAL_DATA_IN,
   input wire logic REAR_MGMT_SERIAL_DATA_O,
   output logic REAR_MGMT_SERIAL_DATA_OUT,
   output logic REAR_MGMT_SERIAL_DATA_OE,
   output logic REAR_MGMT_SERIAL_DATA_RX,
   // Test access
   input wire logic TEST_MODE_SELECT_I,
   input wire logic TEST_CLOCK_I,
   input wire logic TEST_DATA_OUT_I,
   output logic REAR_TEST_MODE_SELECT,
   output logic REAR_TEST_CLOCK,
   output logic REAR_TEST_DATA_OUT,
   output logic REAR_TEST_OE,
   input wire logic REAR_TEST_DATA_IN,
   output logic TEST_DATA_IN_O
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic present_n_s;
   logic limiting_s;
   logic sda_s;
   logic tdo_s;
   rpm_sync u_ps (.clk(CLK_SYS), .rst(RST), .din(REAR_MODULE_PRESENT_N),
      .dout(present_n_s), .rst_val(1'b1));
   // Limiting idles low: a high reset value would look like a limiting burst
   rpm_sync u_lim (.clk(CLK_SYS), .rst(RST), .din(CURRENT_LIMITING),
      .dout(limiting_s), .rst_val(1'b0));
   rpm_sync u_sda (.clk(CLK_SYS), .rst(RST), .din(REAR_MGMT_SERIAL_DATA_IN),
      .dout(sda_s), .rst_val(1'b1));
   rpm_sync u_tdo (.clk(CLK_SYS), .rst(RST), .din(REAR_TEST_DATA_IN),
      .dout(tdo_s), .rst_val(1'b1));
   logic present;
   assign present = ~present_n_s;

   // ------------------------------------------------------------
   // Hot-swap sequencer
   // ------------------------------------------------------------
   rpm_state_t st_q, st_d;
   logic [CNT_W-1:0] tmr_q, tmr_d;
   logic [CNT_W-1:0] lim_q, lim_d;
   logic fault_q, fault_d;
   logic lines_q, lines_d;

   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      fault_d = fault_q;
      lines_d = lines_q;
      // Limit timer only runs while payload is on and limiting persists
      if ((st_q == RPM_START || st_q == RPM_M4) && limiting_s) begin
         lim_d = lim_q + 32'h1;
      end else begin
         lim_d = '0;
      end
      unique case (st_q)
         RPM_M1: begin
            lines_d = 1'b0;
            tmr_d = '0;
            if (present) begin
               st_d = RPM_MGMT;
            end
         end
         RPM_MGMT: begin
            lines_d = 1'b1;
            tmr_d = tmr_q + 32'h1;
            if (!present) begin
               st_d = RPM_M1;
            end else if (tmr_q >= 32'(MGMT_SETTLE_CYCLES - 1)) begin
               st_d = RPM_START;
               tmr_d = '0;
            end
         end
         RPM_START: begin
            tmr_d = tmr_q + 32'h1;
            if (!present) begin
               st_d = RPM_M1;
            end else if (lim_q >= 32'(FAULT_CNT - 1)) begin
               st_d = RPM_FAULT;
               fault_d = 1'b1;
            end else if (tmr_q >= 32'(STARTUP_CNT - 1)) begin
               st_d = RPM_M4;
            end
         end
         RPM_M4: begin
            if (!present) begin
               st_d = RPM_M1;
            end else if (lim_q >= 32'(FAULT_CNT - 1)) begin
               st_d = RPM_FAULT;
               fault_d = 1'b1;
            end
         end
         RPM_FAULT: begin
            // Payload already off; lines stay driven until module leaves
            if (!present) begin
               st_d = RPM_M1;
               fault_d = 1'b0;
            end else if (FAULT_CLEAR) begin
               st_d = RPM_MGMT;
               tmr_d = '0;
               fault_d = 1'b0;
            end
         end
         default: st_d = RPM_M1;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_q <= RPM_M1;
         tmr_q <= '0;
         lim_q <= '0;
         fault_q <= 1'b0;
         lines_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         lim_q <= lim_d;
         fault_q <= fault_d;
         lines_q <= lines_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   logic [7:0] limit_d, limit_q;
   logic pay_d, pay_q, mgmt_d, mgmt_q, z3_d, z3_q;
   logic scl_d, scl_q, sda_d, sda_q, tms_d, tms_q, tck_d, tck_q, tdi_d, tdi_q;
   logic sda_rx_q, tdo_q;

   always_comb begin
      // Lines tri-state one cycle after the state leaves: power is already off
      pay_d = (st_d == RPM_START || st_d == RPM_M4);
      mgmt_d = (st_d != RPM_M1);
      z3_d = (st_d == RPM_M4);
      limit_d = (st_d == RPM_START) ? LIMIT_STARTUP_W : LIMIT_CFG_W;
      if (st_d == RPM_M1) begin
         limit_d = LIMIT_NORMAL_W;
      end
      scl_d = REAR_MGMT_SERIAL_CLOCK_O;
      sda_d = REAR_MGMT_SERIAL_DATA_O;
      tms_d = TEST_MODE_SELECT_I;
      tck_d = TEST_CLOCK_I;
      tdi_d = TEST_DATA_OUT_I;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pay_q <= 1'b0;
         mgmt_q <= 1'b0;
         z3_q <= 1'b0;
         limit_q <= LIMIT_NORMAL_W;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         tms_q <= 1'b1;
         tck_q <= 1'b0;
         tdi_q <= 1'b1;
         sda_rx_q <= 1'b1;
         tdo_q <= 1'b1;
      end else begin
         pay_q <= pay_d;
         mgmt_q <= mgmt_d;
         z3_q <= z3_d;
         limit_q <= limit_d;
         scl_q <= scl_d;
         sda_q <= sda_d;
         tms_q <= tms_d;
         tck_q <= tck_d;
         tdi_q <= tdi_d;
         sda_rx_q <= sda_s;
         tdo_q <= tdo_s;
      end
   end

   assign REAR_PAYLOAD_POWER_OUT = pay_q;
   assign REAR_MGMT_POWER_OUT = mgmt_q;
   assign ZONE3_DRIVE_ENABLE = z3_q;
   assign CURRENT_LIMIT_W = limit_q;
   assign FAULT = fault_q;
   // Open-drain style: clock driven low only, data released when high
   assign REAR_MGMT_SERIAL_CLOCK_OUT = 1'b0;
   assign REAR_MGMT_SERIAL_CLOCK_OE = lines_q & ~scl_q;
   assign REAR_MGMT_SERIAL_DATA_OUT = 1'b0;
   assign REAR_MGMT_SERIAL_DATA_OE = lines_q & ~sda_q;
   assign REAR_MGMT_SERIAL_DATA_RX = sda_rx_q;
   assign REAR_TEST_MODE_SELECT = tms_q;
   assign REAR_TEST_CLOCK = tck_q;
   assign REAR_TEST_DATA_OUT = tdi_q;
   assign REAR_TEST_OE = lines_q;
   assign TEST_DATA_IN_O = tdo_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_z3_only_m4: assert property (@(posedge CLK_SYS) disable iff (RST)
      ZONE3_DRIVE_ENABLE == (st_q == RPM_M4)) else $error("drive enable outside M4");
   a_test_tristate: assert property (@(posedge CLK_SYS) disable iff (RST)
      $rose(present_n_s) |-> ##[1:3] !REAR_TEST_OE) else $error("test lines not released");
   a_serial_tristate: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_q == RPM_M1) |=> !REAR_MGMT_SERIAL_CLOCK_OE && !REAR_MGMT_SERIAL_DATA_OE)
      else $error("serial lines driven while absent");
   a_present_low: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_q == RPM_M1 && !present_n_s) |=> st_q == RPM_MGMT) else $error("insertion missed");
   a_fault_trip: assert property (@(posedge CLK_SYS) disable iff (RST)
      $rose(FAULT) |-> !REAR_PAYLOAD_POWER_OUT && $past(lim_q) >= 32'(FAULT_CNT - 1))
      else $error("fault without full limit time");
   a_start_limit: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_q == RPM_START) |-> CURRENT_LIMIT_W == LIMIT_STARTUP_W) else $error("startup limit");
   a_power_order: assert property (@(posedge CLK_SYS) disable iff (RST)
      $fell(lines_q) |-> !REAR_PAYLOAD_POWER_OUT && !ZONE3_DRIVE_ENABLE)
      else $error("lines released before power off");
   a_pay_switch: assert property (@(posedge CLK_SYS) disable iff (RST)
      ZONE3_DRIVE_ENABLE |-> REAR_PAYLOAD_POWER_OUT) else $error("enable without power");
endmodule : rpm_ctrl
`default_nettype wire

// ---- rpm_pkg.sv ----
// Package: constants and state type for the rear module power controller
package rpm_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int FAULT_TIME_MS = 300;
   localparam int FAULT_CYCLES = (FAULT_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int STARTUP_TIME_MS = 100;
   localparam int STARTUP_CYCLES = (STARTUP_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int MGMT_SETTLE_US = 10;
   localparam int MGMT_SETTLE_CYCLES = (MGMT_SETTLE_US * 1000) / CLK_PERIOD_NS;
   localparam int CNT_W = 32;
   // ------------------------------------------------------------
   // Current limit codes (watts)
   // ------------------------------------------------------------
   localparam int LIM_W = 8;
   localparam logic [7:0] LIMIT_NORMAL_W = 8'h1F;
   localparam logic [7:0] LIMIT_STARTUP_W = 8'h32;
   // Hot-swap states
   typedef enum logic [2:0] {RPM_M1, RPM_MGMT, RPM_START, RPM_M4, RPM_FAULT} rpm_state_t;
endpackage : rpm_pkg

// ---- rpm_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rpm_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic din,
   output logic dout,
   input wire logic rst_val
);
   logic s1_q;
   logic s1_d;
   logic s2_d;
   always_comb begin
      s1_d = din;
      s2_d = s1_q;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= rst_val;
         dout <= rst_val;
      end else begin
         s1_q <= s1_d;
         dout <= s2_d;
      end
   end
endmodule : rpm_sync
`default_nettype wire

// ---- rpm_rear_model.sv ----
// Behavioural model of the rear module and the carrier logic facing it
`timescale 1ns/1ps
`default_nettype none
module rpm_rear_model (
   // System
   input wire logic clk,
   // Bench controls
   input wire logic inserted,
   input wire logic overload,
   // Device pins
   input wire logic payload_on,
   input wire logic sda_oe,
   input wire logic drive_enable,
   output logic present_n,
   output logic limiting,
   output logic sda_level,
   output logic test_data,
   output logic carrier_driving
);
   logic toggle_q = 1'b0;
   always_ff @(posedge clk) begin
      toggle_q <= ~toggle_q;
   end
   // Pulled up: an empty slot reads high
   assign present_n = inserted ? 1'b0 : 1'b1;
   // Switch limits only while payload flows
   assign limiting = overload & payload_on;
   assign sda_level = sda_oe ? 1'b0 : 1'b1;
   // Module shifts data back; an empty slot floats and reads the inverse
   assign test_data = inserted ? toggle_q : ~toggle_q;
   // Carrier keeps its drivers off unless enabled
   assign carrier_driving = drive_enable;
endmodule : rpm_rear_model
`default_nettype wire

// ---- rear_module_power_hotplug_ctrl_bench.sv ----
// Self-checking bench for the rear module power controller
`timescale 1ns/1ps
`default_nettype none
module rear_module_power_hotplug_ctrl_bench
   import rpm_pkg::*;
;
   localparam int FCNT = 20;
   localparam int SCNT = 30;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic insert = 1'b0;
   logic limit_req = 1'b0;
   logic fault_clear = 1'b0;
   logic [7:0] cfg_w = 8'h20;
   logic [2:0] test_drv = 3'h0;
   logic scl_o = 1'b1;
   logic sda_o = 1'b1;
   logic present_n, limiting, sda_pin, tdo_pin, z3_driving;
   logic mgmt_pwr, pay_pwr, fault, z3_en, scl_out, scl_oe, sda_out, sda_oe, sda_rx;
   logic tms, tck, tdi, test_oe, tdo_o;
   logic [7:0] lim_w;
   logic [2:0] drv_prev = 3'h0;
   logic [2:0] tdo_hist;
   logic [2:0] sda_hist;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   int k;
   // ------------------------------------------------------------
   // Clock, timeout, instances
   // ------------------------------------------------------------
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      // Pin history: returned data shows up after two sync stages and one register
      tdo_hist <= {tdo_hist[1:0], tdo_pin};
      sda_hist <= {sda_hist[1:0], sda_pin};
      if (cycles == 30000) begin
         n_mismatch++;
         stop_test();
      end
   end
   rpm_rear_model u_rpm_rear_model (.clk(clk_sys), .inserted(insert), .overload(limit_req),
      .payload_on(pay_pwr), .sda_oe(sda_oe), .drive_enable(z3_en), .present_n(present_n),
      .limiting(limiting), .sda_level(sda_pin), .test_data(tdo_pin),
      .carrier_driving(z3_driving));
   rpm_ctrl #(.FAULT_CNT(FCNT), .STARTUP_CNT(SCNT)) u_rpm_ctrl (.CLK_SYS(clk_sys), .RST(rst),
      .REAR_MODULE_PRESENT_N(present_n), .CURRENT_LIMITING(limiting), .LIMIT_CFG_W(cfg_w),
      .FAULT_CLEAR(fault_clear), .REAR_MGMT_POWER_OUT(mgmt_pwr),
      .REAR_PAYLOAD_POWER_OUT(pay_pwr), .CURRENT_LIMIT_W(lim_w), .FAULT(fault),
      .ZONE3_DRIVE_ENABLE(z3_en), .REAR_MGMT_SERIAL_CLOCK_I(~scl_oe),
      .REAR_MGMT_SERIAL_CLOCK_O(scl_o), .REAR_MGMT_SERIAL_CLOCK_OUT(scl_out),
      .REAR_MGMT_SERIAL_CLOCK_OE(scl_oe), .REAR_MGMT_SERIAL_DATA_IN(sda_pin),
      .REAR_MGMT_SERIAL_DATA_O(sda_o), .REAR_MGMT_SERIAL_DATA_OUT(sda_out),
      .REAR_MGMT_SERIAL_DATA_OE(sda_oe), .REAR_MGMT_SERIAL_DATA_RX(sda_rx),
      .TEST_MODE_SELECT_I(test_drv[0]), .TEST_CLOCK_I(test_drv[1]),
      .TEST_DATA_OUT_I(test_drv[2]), .REAR_TEST_MODE_SELECT(tms), .REAR_TEST_CLOCK(tck),
      .REAR_TEST_DATA_OUT(tdi), .REAR_TEST_OE(test_oe), .REAR_TEST_DATA_IN(tdo_pin),
      .TEST_DATA_IN_O(tdo_o));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task tick();
      @(posedge clk_sys);
      #1;
      drv_prev = test_drv;
      test_drv = 3'($urandom);
   endtask : tick
   task chk(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   task idle_ok();
      chk(sda_oe === 1'b0 && scl_oe === 1'b0 && test_oe === 1'b0, "lines driven");
      chk(z3_en === 1'b0 && pay_pwr === 1'b0, "enable or payload on");
   endtask : idle_ok
   task bring_up();
      insert = 1'b1;
      for (k = 0; k < 10 && mgmt_pwr !== 1'b1; k++) tick();
      chk(mgmt_pwr === 1'b1 && z3_en === 1'b0, "no management power");
      for (k = 0; k < 1100 && pay_pwr !== 1'b1; k++) tick();
      chk(lim_w === LIMIT_STARTUP_W && z3_en === 1'b0, "startup limit");
      for (k = 0; k < SCNT + 10 && z3_en !== 1'b1; k++) tick();
      chk(k == SCNT && z3_en === 1'b1, "startup length");
      chk(lim_w === cfg_w && pay_pwr === 1'b1 && test_oe === 1'b1, "run state");
   endtask : bring_up
   task stop_test();
      if (n_mismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      k = $urandom(32'hBF33C516);
      repeat (20) tick();
      rst = 1'b0;
      chk(lim_w === LIMIT_NORMAL_W && fault === 1'b0, "reset values");
      for (int i = 0; i < 10; i++) begin
         tick();
         idle_ok();
      end
      for (int r = 0; r < 3; r++) begin
         cfg_w = 8'(31 + $urandom_range(49));
         bring_up();
         // Open drain: low level is made by enabling the driver
         scl_o = 1'b0;
         sda_o = 1'b0;
         for (int i = 0; i < 4; i++) begin
            tick();
            chk({tdi, tck, tms} === drv_prev, "test outputs");
            chk(tdo_o === tdo_hist[2] && sda_rx === sda_hist[2], "return lines");
         end
         chk(scl_oe === 1'b1 && sda_oe === 1'b1 && scl_out === 1'b0, "serial drive");
         chk(sda_out === 1'b0, "serial data level");
         scl_o = 1'b1;
         sda_o = 1'b1;
         fault_clear = 1'b1;
         tick();
         fault_clear = 1'b0;
         repeat (3) tick();
         chk(z3_en === 1'b1 && fault === 1'b0, "clear outside fault");
         // A burst shorter than the fault time must not trip
         limit_req = 1'b1;
         repeat (FCNT - 6) tick();
         limit_req = 1'b0;
         repeat (5) tick();
         chk(fault === 1'b0 && z3_en === 1'b1, "short burst tripped");
         limit_req = 1'b1;
         for (k = 0; k < FCNT + 20 && fault !== 1'b1; k++) tick();
         limit_req = 1'b0;
         // Two sync stages sit between the pin and the limit counter
         chk(k == FCNT + 2 && fault === 1'b1, "fault timing");
         chk(pay_pwr === 1'b0 && z3_en === 1'b0, "fault shutdown");
         repeat (10) tick();
         chk(fault === 1'b1 && mgmt_pwr === 1'b1, "fault not held");
         fault_clear = 1'b1;
         tick();
         fault_clear = 1'b0;
         insert = 1'b1;
         for (k = 0; k < 1100 && pay_pwr !== 1'b1; k++) tick();
         chk(pay_pwr === 1'b1 && lim_w === LIMIT_STARTUP_W && fault === 1'b0, "restart");
         repeat ($urandom_range(40)) tick();
         // Removal at a random point of startup or run
         insert = 1'b0;
         for (int i = 0; i < 6; i++) begin
            tick();
            chk(!(test_oe === 1'b0 && (z3_en !== 1'b0 || pay_pwr !== 1'b0)), "order");
         end
         idle_ok();
         chk(mgmt_pwr === 1'b0 && z3_driving === 1'b0, "power left on");
      end
      stop_test();
   end
endmodule : rear_module_power_hotplug_ctrl_bench
`default_nettype wire
